// *** rtl/amrp_fifo.sv ***
// Purpose: small word FIFO in front of the readout shift register
// Assumes: depth is a power of two, at least 2
// Notes:   head word and valid come from registers
`timescale 1ns/10ps
module amrp_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 4
) (
	input  wire logic  clock,
	input  wire logic  rst,
	input  wire logic  ce,
	amrp_word_if.consumer fill,
	amrp_word_if.producer drain
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic [WIDTH-1:0] head_r;
	logic             headValid_r;
	logic             push;
	logic             pop;
	logic [AW-1:0]    rdPtr_nxt;
	logic [AW:0]      count_nxt;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("amrp_fifo: DEPTH must be a power of two, at least 2");
	end

	assign fill.ready  = (count_r != DEPTH[AW:0]);
	assign push        = fill.valid && fill.ready;
	assign pop         = drain.ready && headValid_r;
	assign drain.valid = headValid_r;
	assign drain.data  = head_r;
	assign rdPtr_nxt   = rdPtr_r + AW'(pop);
	assign count_nxt   = count_r + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wrPtr_r] <= fill.data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (ce) begin
			wrPtr_r <= wrPtr_r + AW'(push);
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end

	// bypass: a word written into the slot that becomes head shows next cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			head_r      <= '0;
			headValid_r <= 1'b0;
		end else if (ce) begin
			headValid_r <= (count_nxt != '0);
			if (push && wrPtr_r == rdPtr_nxt) begin
				head_r <= fill.data;
			end else begin
				head_r <= mem[rdPtr_nxt];
			end
		end
	end
endmodule

// *** rtl/amrp_pkg.sv ***
// Purpose: shared constants for the multi-lane readout port
// Assumes: one 25 MHz system clock, synchronous active-high reset
// Notes:   output control field layout and decode codes live here
package amrp_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int WORD_BITS   = 20;
	localparam int SRC_BITS    = 16;
	localparam int FIFO_DEPTH  = 4;
	localparam int SYNC_STAGES = 2;
	localparam int CLOCK_NS    = 40;

	// ----------------------------------------------------------------
	// output protocol control field positions
	// ----------------------------------------------------------------
	localparam int MODE_LSB  = 0;
	localparam int WIDTH_LSB = 2;
	localparam int RATE_BIT  = 4;
	localparam int SEL_LSB   = 6;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_LEGACY = 2'h0;
	localparam logic [1:0] MODE_SRC    = 2'h3;
	localparam logic [1:0] WIDTH_DUAL  = 2'h2;
	localparam logic [1:0] WIDTH_QUAD  = 2'h3;
	localparam logic [1:0] SEL_SCLK    = 2'h0;
	localparam logic [1:0] SEL_INT     = 2'h1;
	localparam logic [1:0] SEL_DIV2    = 2'h2;
	localparam logic [1:0] SEL_DIV4    = 2'h3;
	localparam logic [7:0] OUT_CTL_RST = 8'h00;
	localparam logic [1:0] IN_CTL_RST  = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LEG  = 3'b010,
		ST_SRC  = 3'b100
	} amrp_state_t;

endpackage

// *** rtl/amrp_readout.sv ***
// Purpose: output side of a converter serial port, legacy and
//          source-synchronous read modes on one, two or four lanes
// Assumes: pins are slower than the 25 MHz clock; all are resynchronised
// Notes:   mode is taken from the control ports at each frame start
//
// Functional notes
// - legacy frame delivers the 20-bit output word, source-sync frame its top 16 bits
// - control zero, long frame: daisy-chain shift
// - legacy supports one, two, four lanes
// - dual legacy: two bits per launch edge
// - quad legacy: four bits per launch edge
// - launch edge follows polarity and phase
// - legacy: strobe held low whole frame
// - nonzero control: zeros after word, no chain
// - source-sync: strobe clock aligned with data
// - strobe source: sclk, internal, div2, div4
// - source-sync dual: two bits per rise
// - source-sync quad: four bits per rise
// - SDR: launch on strobe rising edges only
// - DDR: launch both edges, first rising
// - all 24 source, width, rate combinations
// - strobe clocks per frame 16,8,4,2
// - reset gives legacy mode 0 single lane
`timescale 1ns/10ps
module amrp_readout #(
	parameter int WORD_BITS  = amrp_pkg::WORD_BITS,
	parameter int SRC_BITS   = amrp_pkg::SRC_BITS,
	parameter int FIFO_DEPTH = amrp_pkg::FIFO_DEPTH
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire logic                 ce,
	input  wire logic                 chipSelectN,
	input  wire logic                 sclk,
	input  wire logic                 serialIn,
	input  wire logic                 internalOscillatorClock,
	input  wire logic [7:0]           outputProtocolControl,
	input  wire logic [1:0]           writeProtocolSelect,
	input  wire logic [WORD_BITS-1:0] wordData,
	input  wire logic                 wordValid,
	output logic                      wordReady,
	output logic                      serialOutLane0,
	output logic                      serialOutLane1,
	output logic                      serialOutLane2,
	output logic                      serialOutLane3,
	output logic                      readyStrobeOut,
	output logic                      frameActive
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (WORD_BITS < 4 || SRC_BITS < 4 || SRC_BITS > WORD_BITS
		|| (SRC_BITS % 8) != 0) begin : g_chk
		$error("amrp_readout: word sizes out of range");
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] lanesOf(input logic [1:0] widthField);
		if (widthField == amrp_pkg::WIDTH_QUAD) begin
			lanesOf = 3'h4;
		end else if (widthField == amrp_pkg::WIDTH_DUAL) begin
			lanesOf = 3'h2;
		end else begin
			lanesOf = 3'h1;
		end
	endfunction

	// unused lanes stay low so they never toggle in a frame
	function automatic logic [3:0] groupOf(input logic [WORD_BITS-1:0] v,
		input logic [2:0] n);
		groupOf = {v[WORD_BITS-4], v[WORD_BITS-3], v[WORD_BITS-2], v[WORD_BITS-1]};
		if (n == 3'h1) begin
			groupOf = {3'h0, v[WORD_BITS-1]};
		end else if (n == 3'h2) begin
			groupOf = {2'h0, v[WORD_BITS-2], v[WORD_BITS-1]};
		end
	endfunction

	function automatic logic [WORD_BITS-1:0] shiftOf(input logic [WORD_BITS-1:0] v,
		input logic [2:0] n);
		if (n == 3'h4) begin
			shiftOf = {v[WORD_BITS-5:0], 4'h0};
		end else if (n == 3'h2) begin
			shiftOf = {v[WORD_BITS-3:0], 2'h0};
		end else begin
			shiftOf = {v[WORD_BITS-2:0], 1'b0};
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 4;
	localparam int P_CS = 0;
	localparam int P_CK = 1;
	localparam int P_DI = 2;
	localparam int P_IN = 3;

	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] meta_r;
	logic [NPIN-1:0] sync_r;
	logic [NPIN-1:0] prev_r;

	assign pinRaw = {internalOscillatorClock, serialIn, sclk, chipSelectN};

	// meta_r feeds sync_r only; edges compare sync_r with prev_r
	for (genvar i = 0; i < NPIN; i++) begin : g_sync
		always_ff @(posedge clock) begin
			if (rst) begin
				meta_r[i] <= (i == P_CS);
				sync_r[i] <= (i == P_CS);
				prev_r[i] <= (i == P_CS);
			end else if (ce) begin
				meta_r[i] <= pinRaw[i];
				sync_r[i] <= meta_r[i];
				prev_r[i] <= sync_r[i];
			end
		end
	end

	logic csFall;
	logic csRise;
	logic sclkRise;
	logic sclkFall;
	logic intRise;

	assign csFall   = prev_r[P_CS] && !sync_r[P_CS];
	assign csRise   = !prev_r[P_CS] && sync_r[P_CS];
	assign sclkRise = !prev_r[P_CK] && sync_r[P_CK];
	assign sclkFall = prev_r[P_CK] && !sync_r[P_CK];
	assign intRise  = !prev_r[P_IN] && sync_r[P_IN];

	// ----------------------------------------------------------------
	// word buffer
	// ----------------------------------------------------------------
	amrp_word_if #(.WIDTH(WORD_BITS)) inWord ();
	amrp_word_if #(.WIDTH(WORD_BITS)) outWord ();

	assign inWord.data  = wordData;
	assign inWord.valid = wordValid;
	assign wordReady    = inWord.ready;
	// a word is consumed only at frame start, so the buffer really fills
	assign outWord.ready = csFall;

	amrp_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.fill  (inWord),
		.drain (outWord)
	);

	// ----------------------------------------------------------------
	// configuration captured at frame start
	// ----------------------------------------------------------------
	logic [7:0] outCtl_r;
	logic [1:0] inMode_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			outCtl_r <= amrp_pkg::OUT_CTL_RST;
			inMode_r <= amrp_pkg::IN_CTL_RST;
		end else if (ce && csFall) begin
			outCtl_r <= outputProtocolControl;
			inMode_r <= writeProtocolSelect;
		end
	end

	logic [1:0] modeFld;
	logic [1:0] selFld;
	logic [2:0] lanesNow;
	logic       ddrNow;
	logic       chainOn;
	logic       capRising;

	assign modeFld   = outputProtocolControl[amrp_pkg::MODE_LSB +: 2];
	assign selFld    = outCtl_r[amrp_pkg::SEL_LSB +: 2];
	assign lanesNow  = lanesOf(outCtl_r[amrp_pkg::WIDTH_LSB +: 2]);
	assign ddrNow    = outCtl_r[amrp_pkg::RATE_BIT];
	assign chainOn   = (outCtl_r == 8'h00);
	// modes 0 and 3 capture on rising sclk, so they launch on falling
	assign capRising = (inMode_r == 2'h0) || (inMode_r == 2'h3);

	// ----------------------------------------------------------------
	// frame state
	// ----------------------------------------------------------------
	amrp_pkg::amrp_state_t state_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= amrp_pkg::ST_IDLE;
		end else if (ce) begin
			case (state_r)
				amrp_pkg::ST_IDLE: begin
					if (csFall && modeFld == amrp_pkg::MODE_SRC) begin
						state_r <= amrp_pkg::ST_SRC;
					end else if (csFall) begin
						state_r <= amrp_pkg::ST_LEG;
					end
				end
				amrp_pkg::ST_LEG,
				amrp_pkg::ST_SRC: begin
					if (csRise) begin
						state_r <= amrp_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= amrp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign frameActive = (state_r != amrp_pkg::ST_IDLE);

	// ----------------------------------------------------------------
	// strobe source and divider
	// ----------------------------------------------------------------
	logic [1:0] div_r;
	logic       srcLevel;
	logic       srcPrev_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			div_r <= 2'h0;
		end else if (ce && intRise) begin
			div_r <= div_r + 2'h1;
		end
	end

	always_comb begin
		case (selFld)
			amrp_pkg::SEL_SCLK: srcLevel = sync_r[P_CK];
			amrp_pkg::SEL_INT:  srcLevel = sync_r[P_IN];
			amrp_pkg::SEL_DIV2: srcLevel = div_r[0];
			default:            srcLevel = div_r[1];
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			srcPrev_r <= 1'b0;
		end else if (ce) begin
			srcPrev_r <= csFall ? 1'b1 : srcLevel; // a new source must fall before it counts
		end
	end

	// ----------------------------------------------------------------
	// source-synchronous strobe and clock count
	// ----------------------------------------------------------------
	logic       strobe_r;
	logic [4:0] clkLeft_r;
	logic       srcRise;
	logic       srcFall;
	logic       srcLaunch;
	logic [4:0] clkTotal;

	assign srcRise = (state_r == amrp_pkg::ST_SRC) && srcLevel && !srcPrev_r
		&& !strobe_r && clkLeft_r != 5'h0;
	assign srcFall = (state_r == amrp_pkg::ST_SRC) && !srcLevel && srcPrev_r && strobe_r;
	// SDR launches on rises only; DDR also on falls
	assign srcLaunch = srcRise || (srcFall && ddrNow);
	// 16/8/4/2 output clocks for the combined width and rate
	assign clkTotal = 5'(SRC_BITS / (int'(lanesOf(
		outputProtocolControl[amrp_pkg::WIDTH_LSB +: 2]))
		* (outputProtocolControl[amrp_pkg::RATE_BIT] ? 2 : 1)));

	always_ff @(posedge clock) begin
		if (rst) begin
			strobe_r  <= 1'b0;
			clkLeft_r <= 5'h0;
		end else if (ce) begin
			if (csFall) begin
				strobe_r  <= 1'b0;
				clkLeft_r <= (modeFld == amrp_pkg::MODE_SRC) ? clkTotal : 5'h0;
			end else if (csRise || state_r != amrp_pkg::ST_SRC) begin
				strobe_r  <= 1'b0;
				clkLeft_r <= 5'h0;
			end else if (srcRise) begin
				strobe_r <= 1'b1;
			end else if (srcFall) begin
				strobe_r  <= 1'b0;
				clkLeft_r <= clkLeft_r - 5'h1;
			end
		end
	end

	assign readyStrobeOut = strobe_r;

	// ----------------------------------------------------------------
	// legacy launch and capture edges
	// ----------------------------------------------------------------
	logic legLaunch;
	logic legCapture;

	assign legLaunch  = (state_r == amrp_pkg::ST_LEG)
		&& (capRising ? sclkFall : sclkRise);
	assign legCapture = (state_r == amrp_pkg::ST_LEG)
		&& (capRising ? sclkRise : sclkFall);

	// ----------------------------------------------------------------
	// output shift register and lanes
	// ----------------------------------------------------------------
	logic [WORD_BITS-1:0] shift_r;
	logic [3:0]           lanes_r;
	logic [WORD_BITS-1:0] loadWord;
	logic [2:0]           loadLanes;

	assign loadWord  = outWord.valid ? outWord.data : '0;
	assign loadLanes = lanesOf(outputProtocolControl[amrp_pkg::WIDTH_LSB +: 2]);

	always_ff @(posedge clock) begin
		if (rst) begin
			shift_r <= '0;
			lanes_r <= 4'h0;
		end else if (ce) begin
			if (csFall) begin
				// late phase holds lanes low until the first launch edge
				if (modeFld != amrp_pkg::MODE_SRC && !writeProtocolSelect[0]) begin
					lanes_r <= groupOf(loadWord, loadLanes);
					shift_r <= shiftOf(loadWord, loadLanes);
				end else begin
					lanes_r <= 4'h0;
					shift_r <= loadWord;
				end
			end else if (csRise) begin
				lanes_r <= 4'h0;
			end else if (legLaunch || srcLaunch) begin
				// zeros fill behind the word, or chained bits when enabled
				lanes_r <= groupOf(shift_r, lanesNow);
				shift_r <= shiftOf(shift_r, lanesNow);
			end else if (legCapture && chainOn) begin
				shift_r[0] <= sync_r[P_DI];
			end
		end
	end

	assign serialOutLane0 = lanes_r[0];
	assign serialOutLane1 = lanes_r[1];
	assign serialOutLane2 = lanes_r[2];
	assign serialOutLane3 = lanes_r[3];

endmodule

// *** rtl/amrp_word_if.sv ***
// Purpose: valid/ready word carrier between the readout modules
// Assumes: single clock domain
// Notes:   producer drives data and valid, consumer drives ready
`timescale 1ns/10ps
interface amrp_word_if #(
	parameter int WIDTH = 20
);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;

	modport producer (output data, output valid, input ready);
	modport consumer (input data, input valid, output ready);
endinterface

// *** sim/amrp_host_model.sv ***
// Purpose: host controller driving select, serial clock and chain data
// Assumes: every pin change lands on a falling edge of the system clock
// Notes:   sclk stands at its idle level outside frames
`timescale 1ns/10ps
module amrp_host_model #(
	parameter int HALF = 6
) (
	input  wire logic clock,
	input  wire logic serialOutLane0,
	input  wire logic serialOutLane1,
	input  wire logic serialOutLane2,
	input  wire logic serialOutLane3,
	input  wire logic readyStrobeOut,
	output logic      chipSelectN,
	output logic      sclk,
	output logic      serialIn
);
	logic [3:0] lanes;
	assign lanes = {serialOutLane3, serialOutLane2, serialOutLane1, serialOutLane0};

	initial begin
		chipSelectN = 1'b1;
		sclk        = 1'b0; // mode 0 idle level
		serialIn    = 1'b0;
	end

	task automatic grab(input int nBit, inout logic [95:0] got);
		for (int b = 0; b < nBit; b++) begin
			got = {got[94:0], lanes[b]};
		end
	endtask

	// data moves on the launch edge so it is stable well before capture
	task automatic legacyFrame(input logic [1:0] mode, input int nClk, input int nBit,
		input logic [31:0] dIn, output logic [95:0] got);
		got = '0;
		@(negedge clock);
		sclk     = mode[1];
		serialIn = dIn[31];
		repeat (HALF) @(negedge clock);
		chipSelectN = 1'b0;
		repeat (HALF) @(negedge clock);
		for (int i = 0; i < nClk; i++) begin
			if (!mode[0]) grab(nBit, got);
			sclk = ~sclk;
			if (mode[0]) serialIn = dIn[31-i];
			repeat (HALF) @(negedge clock);
			if (mode[0]) grab(nBit, got);
			sclk = ~sclk;
			if (!mode[0]) serialIn = dIn[30-i];
			repeat (HALF) @(negedge clock);
		end
		chipSelectN = 1'b1;
		serialIn    = ~serialIn;
		repeat (HALF) @(negedge clock);
	endtask

	task automatic srcFrame(input logic useSclk, input logic ddr, input int nBit, input int nT,
		output logic [95:0] got, output int rises, output int per);
		logic prev;
		int   tFirst;
		int   tLast;
		got    = '0;
		rises  = 0;
		prev   = 1'b0;
		tFirst = 0;
		tLast  = 0;
		@(negedge clock);
		sclk = 1'b0;
		repeat (HALF) @(negedge clock);
		chipSelectN = 1'b0;
		for (int t = 0; t < nT; t++) begin
			@(negedge clock);
			if (useSclk && (t % HALF) == HALF - 1) sclk = ~sclk;
			if (readyStrobeOut !== prev && (ddr || readyStrobeOut)) grab(nBit, got);
			if (readyStrobeOut && !prev) begin
				if (rises == 0) tFirst = t;
				tLast = t;
				rises++;
			end
			prev = readyStrobeOut;
		end
		per         = (rises > 1) ? (tLast - tFirst) / (rises - 1) : 0;
		chipSelectN = 1'b1;
		sclk        = 1'b0;
		repeat (HALF) @(negedge clock);
	endtask
endmodule

// *** sim/amrp_readout_sva.sv ***
// Purpose: concurrent checks on the readout port pins
// Assumes: control ports held steady while a frame is open
// Notes:   bound onto every amrp_readout instance
`timescale 1ns/10ps
module amrp_readout_sva #(
	parameter int WORD_BITS  = 20,
	parameter int SRC_BITS   = 16,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic                 clock,
	input wire logic                 rst,
	input wire logic                 ce,
	input wire logic                 chipSelectN,
	input wire logic                 sclk,
	input wire logic                 serialIn,
	input wire logic                 internalOscillatorClock,
	input wire logic [7:0]           outputProtocolControl,
	input wire logic [1:0]           writeProtocolSelect,
	input wire logic [WORD_BITS-1:0] wordData,
	input wire logic                 wordValid,
	input wire logic                 wordReady,
	input wire logic                 serialOutLane0,
	input wire logic                 serialOutLane1,
	input wire logic                 serialOutLane2,
	input wire logic                 serialOutLane3,
	input wire logic                 readyStrobeOut,
	input wire logic                 frameActive
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [3:0] lanes;
	logic       srcMode;
	int         widthSh;
	int         riseLim;
	logic [5:0] riseCnt_r;
	assign lanes   = {serialOutLane3, serialOutLane2, serialOutLane1, serialOutLane0};
	assign srcMode = (outputProtocolControl[1:0] == amrp_pkg::MODE_SRC);
	assign widthSh = (outputProtocolControl[3:2] == amrp_pkg::WIDTH_QUAD) ? 2 :
	                 (outputProtocolControl[3:2] == amrp_pkg::WIDTH_DUAL) ? 1 : 0;
	assign riseLim = SRC_BITS >> (widthSh + int'(outputProtocolControl[amrp_pkg::RATE_BIT]));
	// counts strobe rises; a frame that overruns shows one cycle late
	always_ff @(posedge clock) begin
		if (rst || !frameActive) begin
			riseCnt_r <= 6'h00;
		end else if ($rose(readyStrobeOut)) begin
			riseCnt_r <= riseCnt_r + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_late_open;
		$rose(frameActive) && !srcMode && writeProtocolSelect[0];
	endsequence

	a_reset_idle_out: assert property ($fell(rst) |-> !frameActive && !readyStrobeOut
		&& lanes == 4'h0 && wordReady) else $error("outputs not idle after reset");
	a_frame_open_delay: assert property ($fell(chipSelectN) |-> ##[1:4] frameActive)
		else $error("frame not opened after select");
	a_legacy_strobe_low: assert property (!frameActive || !srcMode |-> !readyStrobeOut)
		else $error("strobe high outside source-sync frame");
	a_idle_lanes_zero: assert property (!frameActive && $past(!frameActive) |-> lanes == 4'h0)
		else $error("lanes driven while idle");
	a_single_lanes_low: assert property (frameActive && widthSh == 0 |-> lanes[3:1] == 3'h0)
		else $error("unused lanes active in single width");
	a_dual_lanes_low: assert property (frameActive && widthSh == 1 |-> lanes[3:2] == 2'h0)
		else $error("unused lanes active in dual width");
	a_late_phase_start: assert property (s_late_open |-> lanes == 4'h0)
		else $error("late phase put data out at frame start");
	a_sdr_rise_only: assert property (frameActive && srcMode && !outputProtocolControl[4]
		&& $fell(readyStrobeOut) |-> $stable(lanes)) else $error("launch on strobe fall in sdr");
	a_data_with_strobe: assert property (frameActive && $past(frameActive) && !chipSelectN
		&& srcMode && $changed(lanes) |-> $changed(readyStrobeOut)) else $error("data moved without strobe");
	a_strobe_count_max: assert property (frameActive |-> riseCnt_r <= riseLim)
		else $error("too many strobe clocks in frame");
endmodule

bind amrp_readout amrp_readout_sva #(
	.WORD_BITS(WORD_BITS), .SRC_BITS(SRC_BITS), .FIFO_DEPTH(FIFO_DEPTH)
) chk_u (
	.clock(clock), .rst(rst), .ce(ce), .chipSelectN(chipSelectN), .sclk(sclk),
	.serialIn(serialIn), .internalOscillatorClock(internalOscillatorClock),
	.outputProtocolControl(outputProtocolControl), .writeProtocolSelect(writeProtocolSelect),
	.wordData(wordData), .wordValid(wordValid), .wordReady(wordReady),
	.serialOutLane0(serialOutLane0), .serialOutLane1(serialOutLane1),
	.serialOutLane2(serialOutLane2), .serialOutLane3(serialOutLane3),
	.readyStrobeOut(readyStrobeOut), .frameActive(frameActive)
);

// *** sim/amrp_readout_tb.sv ***
// Purpose: self-checking bench for the multi-lane readout port
// Assumes: inputs change on falling clock edges only
// Notes:   expected streams are rebuilt from the word and control code
`timescale 1ns/10ps
module amrp_readout_tb;
	localparam int LIMIT = 30000;
	localparam int WB    = amrp_pkg::WORD_BITS;
	localparam logic [WB-1:0] WORDS [4] = '{20'h9c3a5, 20'h5a0f1, 20'he1d2b, 20'h3b7c8};

	logic          clock;
	logic          rst;
	logic          ce;
	logic          internalOscillatorClock;
	logic [7:0]    outputProtocolControl;
	logic [1:0]    writeProtocolSelect;
	logic [WB-1:0] wordData;
	logic          wordValid;
	logic          wordReady;
	logic [3:0]    lane;
	logic          readyStrobeOut;
	logic          frameActive;
	logic          chipSelectN;
	logic          sclk;
	logic          serialIn;
	logic [2:0]    oscDiv;
	int            errorCnt;
	int            totalChecks;
	int            cycles;

	amrp_readout dut_u (
		.clock(clock), .rst(rst), .ce(ce), .chipSelectN(chipSelectN), .sclk(sclk),
		.serialIn(serialIn), .internalOscillatorClock(internalOscillatorClock),
		.outputProtocolControl(outputProtocolControl), .writeProtocolSelect(writeProtocolSelect),
		.wordData(wordData), .wordValid(wordValid), .wordReady(wordReady),
		.serialOutLane0(lane[0]), .serialOutLane1(lane[1]), .serialOutLane2(lane[2]),
		.serialOutLane3(lane[3]), .readyStrobeOut(readyStrobeOut), .frameActive(frameActive)
	);
	amrp_host_model #(.HALF(6)) host_u (
		.clock(clock), .serialOutLane0(lane[0]), .serialOutLane1(lane[1]),
		.serialOutLane2(lane[2]), .serialOutLane3(lane[3]), .readyStrobeOut(readyStrobeOut),
		.chipSelectN(chipSelectN), .sclk(sclk), .serialIn(serialIn)
	);

	// ----------------------------------------------------------------
	// clocks and watchdog
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// internal clock of 16 system cycles, well under the resampling limit
	always @(negedge clock) begin
		oscDiv <= oscDiv + 3'h1;
		if (oscDiv == 3'h7) internalOscillatorClock <= ~internalOscillatorClock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errorCnt++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic pushWord(input logic [WB-1:0] w);
		@(negedge clock);
		wordData  = w;
		wordValid = 1'b1;
		@(negedge clock);
		wordValid = 1'b0;
	endtask

	function automatic logic [95:0] legExp(input logic [WB-1:0] w, input int n, input logic chain,
		input logic [31:0] dIn);
		logic [95:0] e;
		e = '0;
		for (int k = 0; k < n; k++) begin
			e = {e[94:0], (k < WB) ? w[WB-1-k] : (chain & dIn[31-(k-WB)])};
		end
		return e;
	endfunction

	task automatic legRun(input logic [7:0] ctl, input logic [1:0] mode, input int nClk,
		input logic [WB-1:0] w, input logic [31:0] dIn);
		logic [95:0] got;
		int          nBit;
		nBit                  = (ctl[3:2] == 2'h3) ? 4 : (ctl[3:2] == 2'h2) ? 2 : 1;
		outputProtocolControl = ctl;
		writeProtocolSelect   = mode;
		host_u.legacyFrame(mode, nClk, nBit, dIn, got);
		check(got, legExp(w, nClk * nBit, ctl == 8'h00, dIn));
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic tReset();
		check({89'h0, lane, readyStrobeOut, frameActive, wordReady}, 96'h1);
	endtask

	// fifo fills and refuses, then four modes drain it, then an empty read
	task automatic tFifoModes();
		for (int i = 0; i < 4; i++) pushWord(WORDS[i]);
		check({95'h0, wordReady}, 96'h0);
		pushWord(20'h0f0f0);
		for (int m = 0; m < 4; m++) legRun(8'h00, 2'(m), 20, WORDS[m], 32'h0);
		legRun(8'h00, 2'h0, 20, 20'h00000, 32'h0);
	endtask

	// full and long frames with nonzero control: ones on the chain input must not show
	task automatic tWide();
		logic [7:0] ctl [5];
		int         nc  [5];
		ctl = '{8'h08, 8'h0c, 8'h08, 8'h0c, 8'h04};
		nc  = '{11, 6, 10, 5, 24};
		for (int i = 0; i < 5; i++) begin
			pushWord(WORDS[i % 4]);
			legRun(ctl[i], 2'(i + 1), nc[i], WORDS[i % 4], 32'hffff_ffff);
		end
	endtask

	task automatic tDaisy();
		pushWord(WORDS[1]);
		legRun(8'h00, 2'h0, 24, WORDS[1], 32'ha5c3_0f00);
	endtask

	// every source, width and rate appears at least once
	task automatic tSrc();
		logic [7:0]  code [10];
		logic [95:0] got;
		int          rises;
		int          per;
		int          sh;
		code = '{8'h03, 8'h43, 8'h83, 8'hc3, 8'h0b, 8'h4f, 8'h13, 8'h5b, 8'h9f, 8'hdf};
		for (int i = 0; i < 10; i++) begin
			sh = ((code[i][3:2] == 2'h3) ? 2 : (code[i][3:2] == 2'h2) ? 1 : 0) + code[i][4];
			pushWord(WORDS[i % 4]);
			outputProtocolControl = code[i];
			host_u.srcFrame(code[i][7:6] == 2'h0, code[i][4], 1 << (sh - code[i][4]),
				(code[i][7:6] == 2'h0) ? 240 : 1200, got, rises, per);
			check(got, {80'h0, WORDS[i % 4][WB-1 -: 16]});
			check(96'(rises), 96'(amrp_pkg::SRC_BITS >> sh));
			check(96'(per), 96'((code[i][7:6] == 2'h0) ? 12 : 8 << code[i][7:6]));
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst                     = 1'b1;
		ce                      = 1'b1;
		internalOscillatorClock = 1'b0;
		oscDiv                  = 3'h0;
		outputProtocolControl   = 8'h00;
		writeProtocolSelect     = 2'h0;
		wordData                = '0;
		wordValid               = 1'b0;
		errorCnt                = 0;
		totalChecks             = 0;
		cycles                  = 0;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		tReset();
		tFifoModes();
		tWide();
		tDaisy();
		tSrc();
		end_of_test();
	end
endmodule
